// [core/exi_pkg.sv]
package exi_pkg;

    // stack slot size in bytes; each stacked item is one 32-bit word
    localparam logic [31:0] EXI_SLOT_BYTES = 32'h0000_0004;
    // vector table index is scaled by the slot size
    localparam int EXI_VEC_SHIFT = 2;
    // interrupt level that can never be masked
    localparam logic [4:0] EXI_NMI_LEVEL = 5'h10;
    // repeat loops of this many instructions or fewer accept nothing
    localparam logic [7:0] EXI_SHORT_LOOP = 8'h03;
    // tail of a long loop that blocks everything
    localparam logic [7:0] EXI_LOOP_TAIL = 8'h03;
    // position from the end that accepts address errors only
    localparam logic [7:0] EXI_LOOP_AE_ONLY = 8'h04;
    // reset values
    localparam logic [31:0] EXI_RST_WORD = 32'h0000_0000;
    localparam logic [7:0] EXI_RST_VEC = 8'h00;

    // entry sequencer states
    typedef enum logic [2:0] {
        EXI_IDLE = 3'b000,
        EXI_PUSH_STAT = 3'b001,
        EXI_PUSH_PC = 3'b010,
        EXI_VEC_RD = 3'b011,
        EXI_JUMP = 3'b100
    } exi_state_e;

    // what started the current entry
    typedef enum logic [2:0] {
        EXI_C_TRAP = 3'b000,
        EXI_C_SLOT = 3'b001,
        EXI_C_ILLEG = 3'b010,
        EXI_C_ADDR = 3'b011,
        EXI_C_IRQ = 3'b100
    } exi_cause_e;

    // one decoded instruction as seen by the exception logic
    typedef struct packed {
        logic undef; // undefined code
        logic pc_write; // rewrites the program counter
        logic dly_branch; // delayed branch
        logic int_dis; // interrupt-disabled load/store of control regs
        logic trap; // software_trap_instruction
        logic [7:0] trap_vec; // vector number of the trap
        logic [31:0] pc; // start address of this instruction
        logic [31:0] next_pc; // address of the following instruction
        logic [31:0] br_target; // branch target when dly_branch
    } exi_dec_s;

    // hardware repeat loop context for the decoded instruction
    typedef struct packed {
        logic active; // instruction belongs to a running loop
        logic [15:0] repeat_count; // remaining iterations
        logic [7:0] len; // instructions in the loop body
        logic [7:0] pos; // position in body, 0 is first
    } exi_rpt_s;

endpackage

// [core/exi_gate.sv]
`timescale 1ns/100ps
module exi_gate
    import exi_pkg::*;
(
    input wire logic in_slot_i, // decoded instruction sits in a delay slot
    input wire logic after_dis_i, // previous one was interrupt-disabled
    input wire exi_rpt_s rpt_i, // repeat loop context
    output logic ok_ae_o, // address errors may be taken here
    output logic ok_irq_o // interrupts may be taken here
);

    // acceptance windows; a zero repeat count means normal execution
    always_comb begin
        ok_ae_o = 1'b1;
        ok_irq_o = 1'b1;
        if (rpt_i.active && rpt_i.repeat_count != 16'h0000) begin // RQ15
            if (rpt_i.len <= EXI_SHORT_LOOP) begin
                ok_ae_o = 1'b0; // RQ12
                ok_irq_o = 1'b0; // RQ12
            end else if (rpt_i.pos == 8'h00 || rpt_i.pos >= rpt_i.len - EXI_LOOP_TAIL) begin
                ok_ae_o = 1'b0; // RQ13
                ok_irq_o = 1'b0; // RQ13
            end else if (rpt_i.pos == rpt_i.len - EXI_LOOP_AE_ONLY) begin
                ok_irq_o = 1'b0; // RQ14
            end
        end
        // RQ15 falls out of the count test above
        if (after_dis_i) begin
            ok_irq_o = 1'b0; // RQ9
        end
        if (in_slot_i) begin
            ok_ae_o = 1'b0; // RQ8
            ok_irq_o = 1'b0; // RQ8
        end
    end

endmodule // exi_gate

// [core/exi_flag.sv]
`timescale 1ns/100ps
module exi_flag
    import exi_pkg::*;
(
    input wire logic clk_i, // core clock
    input wire logic rst_i, // async reset, active high
    input wire logic ce_i, // clock enable
    input wire logic set_i, // event
    input wire logic clr_i, // consume
    output logic flag_o // pending
);

    typedef struct packed {
        logic flag; // sticky pending bit
    } exi_flag_s;

    exi_flag_s s_q;
    exi_flag_s s_d;

    // set beats clear so an event in the consume cycle survives
    always_comb begin
        s_d = s_q;
        if (clr_i) begin
            s_d.flag = 1'b0;
        end
        if (set_i) begin
            s_d.flag = 1'b1; // RQ7
        end
    end

    // state register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign flag_o = s_q.flag;

endmodule // exi_flag

// [core/exi_core.sv]
`timescale 1ns/100ps
// Notes on behaviour
// (RQ1) trap pushes status, next address, jumps vector
// (RQ2) undefined code in delay slot: illegal-slot
// (RQ3) pc-rewriting instruction in slot: illegal-slot
// (RQ4) illegal-slot returns to preceding branch target
// (RQ5) undefined code elsewhere returns to itself
// (RQ6) return address at sp, status above
// (RQ7) blocked address errors stay pending
// (RQ8) delay slot decode accepts nothing
// (RQ9) after interrupt-disabled: address errors only
// (RQ10) control/system loads, stores are interrupt-disabled
// (RQ11) listed jumps, branches, returns are delayed
// (RQ12) loops up to three accept nothing
// (RQ13) long loop first, last three block all
// (RQ14) long loop fourth-from-last: address errors only
// (RQ15) zero repeat count restores normal acceptance
// (RQ16) software keeps stack pointer word aligned
// (RQ17) software keeps vector base word aligned
// (RQ18) stacking error gives one address-error entry
// (RQ19) misaligned stack writes still issue, sp -4
// (RQ20) no manual reset during sensitive register access
// (RQ21) nmi always; others above mask level
// (RQ22) address error taken after instruction completes
// (RQ23) handler at vector base plus four*vector
// (RQ24) address error beats interrupt at decode
module exi_core
    import exi_pkg::*;
#(
    parameter logic [7:0] SLOT_VEC = 8'h06, // illegal-slot vector
    parameter logic [7:0] ILLEG_VEC = 8'h04, // general illegal vector
    parameter logic [7:0] ADDR_VEC = 8'h09 // address error vector
)
(
    input wire logic CLOCK_I, // core clock, 250 MHz
    input wire logic RST_I, // async reset, active high
    input wire logic CE_I, // clock enable, freezes all state
    input wire logic DEC_VALID_I, // one instruction decoded this cycle
    input wire exi_dec_s DEC_I, // decoded instruction class
    input wire exi_rpt_s RPT_I, // repeat loop context
    input wire logic ADDR_ERR_I, // address error from finished instruction
    input wire logic IRQ_REQ_I, // interrupt request level
    input wire logic [4:0] IRQ_LEVEL_I, // request priority, 16 is nmi
    input wire logic [7:0] IRQ_VEC_I, // request vector number
    input wire logic [3:0] MASK_I, // interrupt_mask_level
    input wire logic [31:0] SAVED_STATUS_WORD_I, // status word to push
    input wire logic [31:0] SP_I, // current stack pointer
    input wire logic [31:0] VECTOR_TABLE_BASE_I, // base of the vector table
    output logic MEM_REQ_O, // memory request, held until ack
    output logic MEM_WE_O, // write when high
    output logic [31:0] MEM_ADDR_O, // byte address
    output logic [31:0] MEM_WDATA_O, // write data
    input wire logic MEM_ACK_I, // memory done
    input wire logic MEM_AERR_I, // address error on this cycle, with ack
    input wire logic [31:0] MEM_RDATA_I, // read data, with ack
    output logic BUSY_O, // entry running, decode must stall
    output logic JUMP_O, // pulse: jump to JUMP_PC_O
    output logic [31:0] JUMP_PC_O, // handler address
    output logic SP_WE_O, // pulse: load SP_O into stack pointer
    output logic [31:0] SP_O, // stack pointer after stacking
    output logic IRQ_ACK_O // pulse: interrupt accepted
);

    ////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        exi_state_e st; // sequencer state
        exi_cause_e cause; // cause of the running entry
        logic [31:0] saved_status_word; // captured status word
        logic [31:0] ret_pc; // return address to push
        logic [31:0] sp; // working stack pointer
        logic [31:0] vector_table_base; // captured vector base
        logic [7:0] vec; // vector number
        logic stk_err; // address error seen while stacking
        logic nested; // entry made for a stacking error
        logic in_slot; // last decode was a delayed branch
        logic after_dis; // last decode was interrupt-disabled
        logic [31:0] slot_target; // target of that delayed branch
        logic mem_req; // bus request
        logic mem_we; // bus write
        logic [31:0] mem_addr; // bus address
        logic [31:0] mem_wdata; // bus data
        logic busy; // decode stall
        logic jump; // jump pulse
        logic [31:0] jump_pc; // jump address
        logic sp_we; // stack pointer load pulse
        logic irq_ack; // interrupt accepted pulse
    } exi_core_s;

    exi_core_s s_q;
    exi_core_s s_d;

    logic ok_ae; // gate: address errors allowed here
    logic ok_irq; // gate: interrupts allowed here
    logic ae_pend; // address error waiting for a boundary
    logic irq_ok; // request passes the mask
    logic dec_go; // decode boundary that we may act on
    logic slot_bad; // illegal-slot condition
    logic take_ae; // address error taken now
    logic take_irq; // interrupt taken now
    logic ae_clr; // consume the pending address error

    ////////////////////////////////////////////////////////////////////
    // helpers

    // handler fetch address for a vector number
    function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [7:0] v);
        vec_addr = base + {22'h000000, v, 2'b00}; // RQ23
    endfunction

    // acceptance windows from slot, disabled-instruction and loop context
    exi_gate u_gate (
        .in_slot_i(s_q.in_slot),
        .after_dis_i(s_q.after_dis),
        .rpt_i(RPT_I),
        .ok_ae_o(ok_ae),
        .ok_irq_o(ok_irq)
    );

    // address error raised after its instruction waits for a boundary
    exi_flag u_ae (
        .clk_i(CLOCK_I),
        .rst_i(RST_I),
        .ce_i(CE_I),
        .set_i(ADDR_ERR_I), // RQ22
        .clr_i(ae_clr),
        .flag_o(ae_pend)
    );

    ////////////////////////////////////////////////////////////////////
    // acceptance at the decode boundary

    always_comb begin
        irq_ok = IRQ_REQ_I && (IRQ_LEVEL_I == EXI_NMI_LEVEL ||
                 IRQ_LEVEL_I > {1'b0, MASK_I}); // RQ21
        dec_go = DEC_VALID_I && s_q.st == EXI_IDLE;
        slot_bad = s_q.in_slot && (DEC_I.undef || DEC_I.pc_write); // RQ2 RQ3
        take_ae = dec_go && ae_pend && ok_ae; // RQ7 RQ24
        take_irq = dec_go && !take_ae && irq_ok && ok_irq; // RQ24
        // a stacking-error entry swallows any address error already pending when it starts
        ae_clr = take_ae || (s_q.st == EXI_JUMP && s_q.stk_err && !s_q.nested); // RQ18
    end

    ////////////////////////////////////////////////////////////////////
    // entry sequencer

    always_comb begin
        s_d = s_q;
        s_d.jump = 1'b0;
        s_d.sp_we = 1'b0;
        s_d.irq_ack = 1'b0;
        unique case (s_q.st)
            EXI_IDLE: begin
                if (dec_go) begin
                    // default: plain instruction updates slot tracking
                    s_d.in_slot = DEC_I.dly_branch; // RQ11
                    s_d.after_dis = DEC_I.int_dis; // RQ10
                    s_d.slot_target = DEC_I.br_target;
                    s_d.st = EXI_PUSH_STAT;
                    s_d.nested = 1'b0;
                    s_d.stk_err = 1'b0;
                    s_d.ret_pc = DEC_I.pc;
                    if (take_ae) begin
                        s_d.cause = EXI_C_ADDR; // RQ22
                        s_d.vec = ADDR_VEC;
                    end else if (take_irq) begin
                        s_d.cause = EXI_C_IRQ;
                        s_d.vec = IRQ_VEC_I;
                        s_d.irq_ack = 1'b1;
                    end else if (slot_bad) begin
                        s_d.cause = EXI_C_SLOT;
                        s_d.vec = SLOT_VEC;
                        s_d.ret_pc = s_q.slot_target; // RQ4
                    end else if (DEC_I.undef) begin
                        s_d.cause = EXI_C_ILLEG;
                        s_d.vec = ILLEG_VEC;
                        s_d.ret_pc = DEC_I.pc; // RQ5
                    end else if (DEC_I.trap) begin
                        s_d.cause = EXI_C_TRAP;
                        s_d.vec = DEC_I.trap_vec; // RQ1
                        s_d.ret_pc = DEC_I.next_pc; // RQ1
                    end else begin
                        s_d.st = EXI_IDLE;
                    end
                    if (s_d.st == EXI_PUSH_STAT) begin
                        // handler's first instruction is never in a slot
                        s_d.in_slot = 1'b0;
                        s_d.after_dis = 1'b0;
                        s_d.busy = 1'b1;
                        s_d.saved_status_word = SAVED_STATUS_WORD_I;
                        s_d.vector_table_base = VECTOR_TABLE_BASE_I;
                        // status word first, unaligned or not
                        s_d.sp = SP_I - EXI_SLOT_BYTES; // RQ19
                        s_d.mem_req = 1'b1;
                        s_d.mem_we = 1'b1;
                        s_d.mem_addr = SP_I - EXI_SLOT_BYTES; // RQ6
                        s_d.mem_wdata = SAVED_STATUS_WORD_I;
                    end
                end
            end
            EXI_PUSH_STAT: begin
                if (MEM_ACK_I) begin
                    // errors while stacking a stacking-error entry are ignored
                    s_d.stk_err = s_q.stk_err || (MEM_AERR_I && !s_q.nested); // RQ18
                    s_d.sp = s_q.sp - EXI_SLOT_BYTES; // RQ19
                    s_d.mem_addr = s_q.sp - EXI_SLOT_BYTES; // RQ6
                    s_d.mem_wdata = s_q.ret_pc;
                    s_d.st = EXI_PUSH_PC;
                end
            end
            EXI_PUSH_PC: begin
                if (MEM_ACK_I) begin
                    s_d.stk_err = s_q.stk_err || (MEM_AERR_I && !s_q.nested); // RQ18
                    s_d.mem_we = 1'b0;
                    s_d.mem_addr = vec_addr(s_q.vector_table_base, s_q.vec); // RQ23
                    s_d.mem_wdata = EXI_RST_WORD;
                    s_d.st = EXI_VEC_RD;
                end
            end
            EXI_VEC_RD: begin
                if (MEM_ACK_I) begin
                    // jump is immediate, no delay slot follows it
                    s_d.mem_req = 1'b0;
                    s_d.jump = 1'b1; // RQ1
                    s_d.jump_pc = MEM_RDATA_I;
                    s_d.sp_we = 1'b1; // RQ6
                    s_d.st = EXI_JUMP;
                end
            end
            EXI_JUMP: begin
                if (s_q.stk_err && !s_q.nested) begin
                    // one address-error entry after the original, never a loop
                    s_d.st = EXI_PUSH_STAT; // RQ18
                    s_d.nested = 1'b1;
                    s_d.stk_err = 1'b0;
                    s_d.cause = EXI_C_ADDR;
                    s_d.vec = ADDR_VEC;
                    s_d.ret_pc = s_q.jump_pc;
                    s_d.saved_status_word = SAVED_STATUS_WORD_I;
                    s_d.sp = s_q.sp - EXI_SLOT_BYTES;
                    s_d.mem_req = 1'b1;
                    s_d.mem_we = 1'b1;
                    s_d.mem_addr = s_q.sp - EXI_SLOT_BYTES;
                    s_d.mem_wdata = SAVED_STATUS_WORD_I;
                end else begin
                    s_d.st = EXI_IDLE;
                    s_d.busy = 1'b0;
                end
            end
            default: begin
                s_d.st = EXI_IDLE; // unused codes recover to idle
                s_d.busy = 1'b0;
                s_d.mem_req = 1'b0;
            end
        endcase
    end

    // state register
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            s_q <= '0;
        end else if (CE_I) begin
            s_q <= s_d;
        end
    end

    assign MEM_REQ_O = s_q.mem_req;
    assign MEM_WE_O = s_q.mem_we;
    assign MEM_ADDR_O = s_q.mem_addr;
    assign MEM_WDATA_O = s_q.mem_wdata;
    assign BUSY_O = s_q.busy;
    assign JUMP_O = s_q.jump;
    assign JUMP_PC_O = s_q.jump_pc;
    assign SP_WE_O = s_q.sp_we;
    assign SP_O = s_q.sp;
    assign IRQ_ACK_O = s_q.irq_ack;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);

    a_trap_return: assert property (CE_I && dec_go && DEC_I.trap && !slot_bad // RQ1
        && !DEC_I.undef && !take_ae && !take_irq |=> s_q.ret_pc == $past(DEC_I.next_pc))
        else $error("trap pushed wrong return address");
    a_slot_return: assert property (CE_I && dec_go && slot_bad // RQ4
        |=> s_q.cause == EXI_C_SLOT && s_q.ret_pc == $past(s_q.slot_target))
        else $error("illegal slot return address wrong");
    a_illeg_return: assert property (CE_I && dec_go && !s_q.in_slot && DEC_I.undef // RQ5
        && !take_ae && !take_irq |=> s_q.cause == EXI_C_ILLEG && s_q.ret_pc == $past(DEC_I.pc))
        else $error("general illegal return address wrong");
    a_slot_quiet: assert property (CE_I && dec_go && s_q.in_slot // RQ8
        |=> s_q.cause != EXI_C_ADDR || s_q.st == EXI_IDLE)
        else $error("address error taken in delay slot");
    a_irq_mask: assert property (s_q.irq_ack |-> $past(IRQ_LEVEL_I) == EXI_NMI_LEVEL // RQ21
        || $past(IRQ_LEVEL_I) > {1'b0, $past(MASK_I)})
        else $error("masked interrupt accepted");
    a_ae_first: assert property (CE_I && dec_go && ae_pend && ok_ae // RQ24
        |=> !s_q.irq_ack && s_q.cause == EXI_C_ADDR)
        else $error("interrupt beat address error");
    a_push_order: assert property (CE_I && s_q.st == EXI_PUSH_STAT && MEM_ACK_I // RQ6
        |=> s_q.mem_we && s_q.mem_wdata == s_q.ret_pc
        && s_q.mem_addr == $past(s_q.mem_addr) - EXI_SLOT_BYTES)
        else $error("stacking order or step wrong");
    a_vec_fetch: assert property (s_q.st == EXI_VEC_RD |-> !s_q.mem_we // RQ23
        && s_q.mem_addr == s_q.vector_table_base + {22'h000000, s_q.vec, 2'b00})
        else $error("vector fetch address wrong");
    a_nest_once: assert property (CE_I && s_q.st == EXI_JUMP && s_q.nested // RQ18
        |=> s_q.st == EXI_IDLE)
        else $error("stacking error entry repeated");
    a_gate_loop: assert property (dec_go && RPT_I.active // RQ12
        && RPT_I.repeat_count != 16'h0000 && RPT_I.len <= EXI_SHORT_LOOP
        |-> !take_ae && !take_irq)
        else $error("exception taken in short loop");

    c_trap: cover property (s_q.st == EXI_JUMP && s_q.cause == EXI_C_TRAP);
    c_slot: cover property (s_q.st == EXI_JUMP && s_q.cause == EXI_C_SLOT);
    c_nested: cover property (s_q.st == EXI_JUMP && s_q.nested);
    c_irq: cover property (s_q.irq_ack);

endmodule // exi_core

// [verif/exi_mem_model.sv]
`timescale 1ns/100ps
module exi_mem_model
    import exi_pkg::*;
#(
    parameter logic [31:0] HND_OFS = 32'h4000_0000 // handler word = its address plus this
)
(
    input wire logic clk_i, // core clock
    input wire logic rst_i, // async reset, active high
    input wire logic slow_i, // add three wait states
    input wire logic req_i, // request, held until ack
    input wire logic we_i, // write when high
    input wire logic [31:0] addr_i, // byte address
    input wire logic [31:0] wdata_i, // write data, logged by the bench
    output logic ack_o, // one-cycle completion
    output logic aerr_o, // misaligned access, valid with ack
    output logic [31:0] rdata_o // read data, valid with ack
);
    logic [1:0] wait_q; // wait states spent on this request

    ////////////////////////////////////////////////////////////////
    // one ack per request; the cycle after an ack is idle so a held request is not answered twice
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            aerr_o <= 1'b0;
            rdata_o <= 32'h0000_0000;
            wait_q <= 2'h0;
        end else if (ack_o) begin
            ack_o <= 1'b0;
            aerr_o <= 1'b1; // no answer: junk level
            rdata_o <= ~rdata_o; // released data never repeats the last word
            wait_q <= 2'h0;
        end else if (req_i && (!slow_i || wait_q == 2'h3)) begin
            ack_o <= 1'b1;
            aerr_o <= (addr_i[1:0] != 2'h0);
            rdata_o <= we_i ? wdata_i : addr_i + HND_OFS; // writes echo, reads see the table
        end else begin
            aerr_o <= 1'b1;
            rdata_o <= ~rdata_o;
            wait_q <= req_i ? wait_q + 2'h1 : 2'h0;
        end
    end
endmodule // exi_mem_model

// [verif/exi_core_tb.sv]
`timescale 1ns/100ps
module exi_core_tb;
    import exi_pkg::*;
    localparam logic [7:0] SV = 8'h06; // illegal-slot vector
    localparam logic [7:0] IV = 8'h04; // general illegal vector
    localparam logic [7:0] AV = 8'h09; // address error vector
    localparam logic [31:0] HOFS = 32'h4000_0000; // partner's handler offset
    logic clk = 1'b0, rst = 1'b1, dv = 1'b0, aerr_in = 1'b0, irq = 1'b0, slow = 1'b0;
    exi_dec_s dec = '0; // decoded instruction
    exi_rpt_s rpt = '0; // loop context
    logic [4:0] lvl = 5'h05;
    logic [7:0] ivec = 8'h40;
    logic [3:0] mask = 4'h0;
    logic [31:0] saved_status_word = 32'h0000_00f0, sp = 32'h0000_2000;
    logic [31:0] vector_table_base = 32'h0000_1000;
    logic req, we, ack, maerr, busy, jmp, spwe, iack;
    logic [31:0] addr, wdata, rdata, jpc, spo;
    logic [31:0] wa[$], wd[$]; // stack writes seen at the memory port
    int n_errors = 0, cmp_count = 0;

    always #2 clk = ~clk; // 250 MHz

    exi_core #(.SLOT_VEC(SV), .ILLEG_VEC(IV), .ADDR_VEC(AV)) DUT (.CLOCK_I(clk), .RST_I(rst),
        .CE_I(1'b1), .DEC_VALID_I(dv), .DEC_I(dec), .RPT_I(rpt), .ADDR_ERR_I(aerr_in),
        .IRQ_REQ_I(irq), .IRQ_LEVEL_I(lvl), .IRQ_VEC_I(ivec), .MASK_I(mask),
        .SAVED_STATUS_WORD_I(saved_status_word), .SP_I(sp),
        .VECTOR_TABLE_BASE_I(vector_table_base), .MEM_REQ_O(req), .MEM_WE_O(we),
        .MEM_ADDR_O(addr),
        .MEM_WDATA_O(wdata), .MEM_ACK_I(ack), .MEM_AERR_I(maerr), .MEM_RDATA_I(rdata),
        .BUSY_O(busy), .JUMP_O(jmp), .JUMP_PC_O(jpc), .SP_WE_O(spwe), .SP_O(spo),
        .IRQ_ACK_O(iack));
    exi_mem_model #(.HND_OFS(HOFS)) mem (.clk_i(clk), .rst_i(rst), .slow_i(slow), .req_i(req),
        .we_i(we), .addr_i(addr), .wdata_i(wdata), .ack_o(ack), .aerr_o(maerr), .rdata_o(rdata));

    ////////////////////////////////////////////////////////////////
    // log completed writes with the same edge the core uses
    always @(posedge clk) begin
        if (req === 1'b1 && ack === 1'b1 && we === 1'b1) begin
            wa.push_back(addr);
            wd.push_back(wdata);
        end
    end

    task automatic wrap_up;
        if (n_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // instruction builder: next is pc+2, branch target pc+0x100
    function automatic exi_dec_s mk(input logic [4:0] k, input logic [7:0] v, input logic [31:0] pc);
        mk = '{k[4], k[3], k[2], k[1], k[0], v, pc, pc + 32'h2, pc + 32'h100};
    endfunction

    task automatic decode(input exi_dec_s d, input exi_rpt_s r);
        @(negedge clk);
        dec = d;
        rpt = r;
        dv = 1'b1;
        @(negedge clk);
        dv = 1'b0;
        rpt = '0;
    endtask

    task automatic pulse_ae;
        @(negedge clk);
        aerr_in = 1'b1;
        @(negedge clk);
        aerr_in = 1'b0;
    endtask

    // bounded wait for the jump pulse; drops the interrupt once acknowledged
    task automatic wait_jump(output logic seen);
        int n;
        seen = 1'b0;
        for (n = 0; n < 80; n++) begin
            if (iack === 1'b1) begin
                seen = 1'b1;
                irq = 1'b0;
            end
            if (jmp === 1'b1)
                break;
            @(negedge clk);
        end
        if (n == 80) begin
            n_errors++;
            wrap_up();
        end
    endtask

    task automatic entry(input logic [31:0] ret, input logic [7:0] vec, input logic irq_exp);
        logic seen;
        wait_jump(seen);
        chk(jpc, vector_table_base + {22'h0, vec, 2'b00} + HOFS);
        chk(spo, sp - 32'h8);
        chk({31'h0, spwe}, 32'h1);
        chk(wa.size(), 2);
        chk(wa[0], sp - 32'h4);
        chk(wd[0], saved_status_word);
        chk(wa[1], sp - 32'h8);
        chk(wd[1], ret);
        chk({31'h0, seen}, {31'h0, irq_exp});
        @(negedge clk);
        chk({31'h0, busy}, 32'h0);
        wa.delete();
        wd.delete();
    endtask

    task automatic noentry;
        repeat (3) @(negedge clk);
        chk({31'h0, busy}, 32'h0);
        chk(wa.size(), 0);
    endtask

    ////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_instr;
        slow = 1'b1; // stalled memory on the first entry
        decode(mk(5'h01, 8'h21, 32'h500), '0);
        entry(32'h502, 8'h21, 1'b0);
        slow = 1'b0;
        decode(mk(5'h04, 8'h00, 32'h600), '0);
        decode(mk(5'h10, 8'h00, 32'h602), '0);
        entry(32'h700, SV, 1'b0);
        decode(mk(5'h04, 8'h00, 32'h600), '0);
        decode(mk(5'h09, 8'h22, 32'h602), '0); // trap sitting in a slot
        entry(32'h700, SV, 1'b0);
        decode(mk(5'h10, 8'h00, 32'h800), '0);
        entry(32'h800, IV, 1'b0);
    endtask

    task automatic t_slot_hold;
        decode(mk(5'h04, 8'h00, 32'h900), '0);
        irq = 1'b1;
        pulse_ae();
        decode(mk(5'h00, 8'h00, 32'h902), '0);
        noentry();
        decode(mk(5'h00, 8'h00, 32'ha00), '0);
        entry(32'ha00, AV, 1'b0);
        decode(mk(5'h00, 8'h00, 32'ha10), '0);
        entry(32'ha10, 8'h40, 1'b1);
    endtask

    task automatic t_dis_mask;
        decode(mk(5'h02, 8'h00, 32'hb00), '0);
        irq = 1'b1;
        decode(mk(5'h00, 8'h00, 32'hb02), '0);
        noentry();
        irq = 1'b0;
        decode(mk(5'h02, 8'h00, 32'hb04), '0);
        pulse_ae();
        decode(mk(5'h00, 8'h00, 32'hb06), '0);
        entry(32'hb06, AV, 1'b0);
        mask = 4'h5; // level equal to mask is refused
        irq = 1'b1;
        decode(mk(5'h00, 8'h00, 32'hb10), '0);
        noentry();
        mask = 4'hf;
        lvl = 5'h10; // nmi ignores the mask
        decode(mk(5'h00, 8'h00, 32'hb20), '0);
        entry(32'hb20, 8'h40, 1'b1);
        mask = 4'h0;
        lvl = 5'h05;
    endtask

    task automatic t_loop;
        exi_rpt_s blk[4];
        blk = '{'{1'b1, 16'h5, 8'h3, 8'h1}, '{1'b1, 16'h5, 8'h8, 8'h0},
                '{1'b1, 16'h5, 8'h8, 8'h5}, '{1'b1, 16'h5, 8'h8, 8'h7}};
        pulse_ae();
        foreach (blk[i]) begin
            decode(mk(5'h00, 8'h00, 32'hc00), blk[i]);
            noentry();
        end
        decode(mk(5'h00, 8'h00, 32'hc04), '{1'b1, 16'h5, 8'h8, 8'h4});
        entry(32'hc04, AV, 1'b0);
        irq = 1'b1;
        decode(mk(5'h00, 8'h00, 32'hc04), '{1'b1, 16'h5, 8'h8, 8'h4});
        noentry();
        decode(mk(5'h00, 8'h00, 32'hc08), '{1'b1, 16'h0, 8'h3, 8'h1});
        entry(32'hc08, 8'h40, 1'b1);
    endtask

    task automatic t_misaligned;
        logic seen;
        sp = 32'h0000_2002;
        decode(mk(5'h01, 8'h23, 32'hd00), '0);
        wait_jump(seen);
        chk(jpc, vector_table_base + 32'h8c + HOFS);
        chk(wa[0], 32'h0000_1ffe);
        chk(wa[1], 32'h0000_1ffa);
        chk(spo, 32'h0000_1ffa);
        @(negedge clk);
        wait_jump(seen);
        chk(jpc, vector_table_base + {22'h0, AV, 2'b00} + HOFS);
        chk(wa[2], 32'h0000_1ff6);
        chk(wa[3], 32'h0000_1ff2);
        chk(wd[3], vector_table_base + 32'h8c + HOFS);
        chk(spo, 32'h0000_1ff2);
        wa.delete();
        wd.delete();
        noentry();
        sp = 32'h0000_2000;
    endtask

    initial begin
        // reset only before any traffic, never in the middle of an access
        repeat (4) @(negedge clk);
        rst = 1'b0;
        t_instr();
        t_slot_hold();
        t_dis_mask();
        t_loop();
        t_misaligned();
        wrap_up();
    end
endmodule // exi_core_tb
